// File: common/sbs_map.vh
`ifndef SBS_MAP_VH
`define SBS_MAP_VH

// pin-level widths of the array and its buses
`define SBS_ADDR_W 17
`define SBS_DATA_W 32
`define SBS_PAR_W 4
`define SBS_LANES 4
`define SBS_LANE_W 9

// apb register byte offsets
`define SBS_APB_ADDR_W 8
`define SBS_REG_CTRL 8'h00
`define SBS_REG_STATUS 8'h04

// control register fields
`define SBS_CTRL_SOFT_SLEEP 0
`define SBS_CTRL_RESET 32'h0000_0000

// status register fields
`define SBS_STAT_ASLEEP 0
`define SBS_STAT_INTERLEAVE 1
`define SBS_STAT_ACTIVE 2
`define SBS_STAT_WRITE 3
`define SBS_STAT_ADDR_LSB 4
`define SBS_STAT_ADDR_MSB 20

// pad pull levels seen before the first real sample
`define SBS_SLEEP_PULL 1'b0
`define SBS_MODE_PULL 1'b1

`endif

// File: hw/sbs_mem.v
`timescale 1ns/1ps
`default_nettype none

// lane-writable array; read data always come out of a register
module sbs_mem #(
	parameter ADDR_W = 17,
	parameter LANES = 4,
	parameter LANE_W = 9
) (
	input wire clk_i,
	input wire [ADDR_W-1:0] rd_addr_i,
	input wire [ADDR_W-1:0] wr_addr_i,
	input wire [LANES-1:0] wr_lane_i,
	input wire [LANES*LANE_W-1:0] wr_data_i,
	output wire [LANES*LANE_W-1:0] rd_data_o
);

	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : lane
			reg [LANE_W-1:0] store [0:(1<<ADDR_W)-1];
			reg [LANE_W-1:0] q;
			// no reset on the array: contents survive sleep and reset alike
			always @(posedge clk_i) begin
				if (wr_lane_i[g]) begin
					store[wr_addr_i] <= wr_data_i[g*LANE_W +: LANE_W];
				end
				q <= store[rd_addr_i];
			end
			assign rd_data_o[g*LANE_W +: LANE_W] = q;
		end
	endgenerate

endmodule

`default_nettype wire

// File: hw/sbs_sram_ctrl.v
// What this block does
// (R01) chip select c is sampled, active low, and joined with selects a and b
// (R02) output enable acts without clock; low drives data lines, high releases them
// (R03) sleep high gives standby, ignores other inputs, keeps array contents
// (R04) sleep input defaults low, so the device stays awake
// (R05) mode strap high picks interleaved burst order, low picks linear
// (R06) mode strap defaults high, giving interleaved order
// (R07) data and parity lines are captured in an input register each rising edge
// (R08) driven data are those of the address sampled at the previous edge
// (R09) a detected write cycle releases data and parity lines whatever enable says
// (R10) when both strobes are asserted only the processor strobe counts; here it counts only with select a low, else the controller strobe counts
// (R11) advance low steps the two-bit burst counter in the chosen order
// (R12) all-bytes write writes every lane and overrides the lane write inputs
// (R13) the controller raises output enable before driving write data
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.vh"

module sbs_sram_ctrl #(
	parameter ADDR_W = `SBS_ADDR_W
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [ADDR_W-1:0] addr_i,
	input wire chip_select_a_n_i,
	input wire chip_select_b_i,
	input wire chip_select_c_n_i,
	input wire proc_addr_strobe_n_i,
	input wire ctrl_addr_strobe_n_i,
	input wire burst_step_n_i,
	input wire all_bytes_write_n_i,
	input wire byte_write_gate_n_i,
	input wire [`SBS_LANES-1:0] lane_write_sel_n_i,
	input wire output_enable_n_i,
	input wire sleep_request_i,
	input wire mode_strap_i,
	input wire [`SBS_DATA_W-1:0] dq_i,
	output wire [`SBS_DATA_W-1:0] dq_o,
	output wire dq_oe_o,
	input wire [`SBS_PAR_W-1:0] parity_io_i,
	output wire [`SBS_PAR_W-1:0] parity_io_o,
	output wire parity_io_oe_o,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [`SBS_APB_ADDR_W-1:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output wire pready_o,
	output reg pslverr_o
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ACTIVE = 3'b010;
	localparam [2:0] ST_SLEEP = 3'b100;
	localparam LW = `SBS_LANE_W;
	// full control word reset value; only the soft sleep bit is stored
	localparam [31:0] CTRL_RST = `SBS_CTRL_RESET;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [2:0] sleep_sync;
	reg [2:0] mode_sync;
	reg sleep_level;
	reg interleave;
	reg soft_sleep;
	reg [ADDR_W-1:0] base_addr;
	reg [1:0] step;
	reg [ADDR_W-1:0] next_base_addr;
	reg [1:0] next_step;
	reg rd_valid;
	reg next_rd_valid;
	reg wr_cycle;
	reg next_wr_cycle;
	reg [`SBS_LANES-1:0] wr_lane;
	reg [`SBS_LANES-1:0] next_wr_lane;
	reg [ADDR_W-1:0] wr_addr;
	reg [`SBS_DATA_W-1:0] din_q;
	reg [`SBS_PAR_W-1:0] pin_q;
	wire [`SBS_LANES*LW-1:0] wr_word;
	wire [`SBS_LANES*LW-1:0] rd_word;
	wire [ADDR_W-1:0] cur_addr;
	wire [ADDR_W-1:0] next_addr;
	wire selected;
	wire proc_start;
	wire ctrl_start;
	wire write_req;
	wire [`SBS_LANES-1:0] lane_mask;
	wire [1:0] lsb_now;

	// three-stage synchronisers for the asynchronous pins; stage 0 feeds only stage 1
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_sync <= {3{`SBS_SLEEP_PULL}}; // [R04]
			mode_sync <= {3{`SBS_MODE_PULL}}; // [R06]
		end else begin
			sleep_sync <= {sleep_sync[1:0], sleep_request_i};
			mode_sync <= {mode_sync[1:0], mode_strap_i};
		end
	end

	// a level change counts only once stages one and two agree
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_level <= `SBS_SLEEP_PULL; // [R04]
			interleave <= `SBS_MODE_PULL; // [R06]
		end else begin
			if (sleep_sync[2] == sleep_sync[1]) begin
				sleep_level <= sleep_sync[2];
			end
			if (mode_sync[2] == mode_sync[1]) begin
				interleave <= mode_sync[2]; // [R05]
			end
		end
	end

	// select and strobe decoding; selects a gates the processor strobe
	assign selected = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i; // [R01]
	assign proc_start = !proc_addr_strobe_n_i && !chip_select_a_n_i;
	assign ctrl_start = !ctrl_addr_strobe_n_i && !proc_start; // [R10]

	// all-bytes write overrides the gated lane selects
	assign lane_mask = !all_bytes_write_n_i ? {`SBS_LANES{1'b1}} :
		(!byte_write_gate_n_i ? ~lane_write_sel_n_i : {`SBS_LANES{1'b0}}); // [R12]
	assign write_req = |lane_mask;

	// burst order: interleaved flips bits of the start, linear adds modulo four
	assign lsb_now = interleave ? (base_addr[1:0] ^ step) : (base_addr[1:0] + step); // [R05]
	assign cur_addr = {base_addr[ADDR_W-1:2], lsb_now};

	// access sequencing
	always @* begin
		next_state = state;
		next_base_addr = base_addr;
		next_step = step;
		next_rd_valid = 1'b0;
		next_wr_cycle = 1'b0;
		next_wr_lane = {`SBS_LANES{1'b0}};
		case (state)
			ST_IDLE, ST_ACTIVE: begin
				if (sleep_level || soft_sleep) begin
					next_state = ST_SLEEP; // [R03]
				end else if (proc_start || ctrl_start) begin
					if (selected) begin
						next_state = ST_ACTIVE;
						next_base_addr = addr_i;
						next_step = 2'd0;
						// the processor strobe ignores write inputs in its first cycle
						if (ctrl_start && write_req) begin
							next_wr_cycle = 1'b1;
							next_wr_lane = lane_mask;
						end else begin
							next_rd_valid = 1'b1;
						end
					end else begin
						next_state = ST_IDLE;
					end
				end else if (state == ST_ACTIVE) begin
					if (!burst_step_n_i) begin
						next_step = step + 2'd1; // [R11]
					end
					if (write_req) begin
						next_wr_cycle = 1'b1;
						next_wr_lane = lane_mask; // [R12]
					end else begin
						next_rd_valid = 1'b1;
					end
				end
			end
			ST_SLEEP: begin
				// everything but the sleep request is ignored here
				if (!sleep_level && !soft_sleep) begin
					next_state = ST_IDLE; // [R03]
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	assign next_addr = {next_base_addr[ADDR_W-1:2],
		(interleave ? (next_base_addr[1:0] ^ next_step) : (next_base_addr[1:0] + next_step))};

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			base_addr <= {ADDR_W{1'b0}};
			step <= 2'd0;
			rd_valid <= 1'b0;
			wr_cycle <= 1'b0;
			wr_lane <= {`SBS_LANES{1'b0}};
			wr_addr <= {ADDR_W{1'b0}};
		end else begin
			state <= next_state;
			base_addr <= next_base_addr;
			step <= next_step;
			rd_valid <= next_rd_valid; // [R08]
			wr_cycle <= next_wr_cycle;
			wr_lane <= next_wr_lane;
			wr_addr <= next_addr;
		end
	end

	// input register on the shared lines; the array write lands one edge later
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			din_q <= {`SBS_DATA_W{1'b0}};
			pin_q <= {`SBS_PAR_W{1'b0}};
		end else begin
			din_q <= dq_i; // [R07]
			pin_q <= parity_io_i; // [R07]
		end
	end

	genvar g;
	generate
		for (g = 0; g < `SBS_LANES; g = g + 1) begin : pack
			assign wr_word[g*LW +: LW] = {pin_q[g], din_q[g*8 +: 8]};
			assign dq_o[g*8 +: 8] = rd_word[g*LW +: 8];
			assign parity_io_o[g] = rd_word[g*LW + 8];
		end
	endgenerate

	// read address is the coming cycle's, so data arrive flow-through after the edge
	sbs_mem #(
		.ADDR_W(ADDR_W),
		.LANES(`SBS_LANES),
		.LANE_W(LW)
	) u_mem (
		.clk_i(clk_i),
		.rd_addr_i(next_addr), // [R08]
		.wr_addr_i(wr_addr),
		.wr_lane_i(wr_lane),
		.wr_data_i(wr_word),
		.rd_data_o(rd_word)
	);

	// the enable pin is combinational so it acts at once; a write cycle always wins
	assign dq_oe_o = !output_enable_n_i && rd_valid && !wr_cycle && !state[2]; // [R02] [R09]
	assign parity_io_oe_o = dq_oe_o; // [R02] [R09]

	// apb slave, zero wait: answer formed in the setup cycle, ready in access
	assign pready_o = 1'b1;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			soft_sleep <= CTRL_RST[`SBS_CTRL_SOFT_SLEEP];
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			if (psel_i && penable_i && pwrite_i && paddr_i == `SBS_REG_CTRL) begin
				soft_sleep <= pwdata_i[`SBS_CTRL_SOFT_SLEEP];
			end
			if (psel_i && !penable_i) begin
				prdata_o <= 32'h0000_0000;
				pslverr_o <= 1'b0;
				case (paddr_i)
					`SBS_REG_CTRL: begin
						prdata_o[`SBS_CTRL_SOFT_SLEEP] <= soft_sleep;
					end
					`SBS_REG_STATUS: begin
						// status is read-only; a write there is an error
						pslverr_o <= pwrite_i;
						prdata_o[`SBS_STAT_ASLEEP] <= state[2];
						prdata_o[`SBS_STAT_INTERLEAVE] <= interleave;
						prdata_o[`SBS_STAT_ACTIVE] <= state[1];
						prdata_o[`SBS_STAT_WRITE] <= wr_cycle;
						prdata_o[`SBS_STAT_ADDR_MSB:`SBS_STAT_ADDR_LSB] <= cur_addr;
					end
					default: begin
						pslverr_o <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// File: test/sbs_sram_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches pin direction, selection and the apb error answer
module sbs_sram_chk (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic chip_select_a_n_i,
	input wire logic chip_select_b_i,
	input wire logic chip_select_c_n_i,
	input wire logic proc_addr_strobe_n_i,
	input wire logic ctrl_addr_strobe_n_i,
	input wire logic all_bytes_write_n_i,
	input wire logic output_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic dq_oe_o,
	input wire logic parity_io_oe_o,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic pslverr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// sampled selection and strobes; the sleep pin needs six quiet edges to settle
	wire sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
	wire ps = !proc_addr_strobe_n_i;
	wire cs = !ctrl_addr_strobe_n_i;
	wire rd_ok = !output_enable_n_i && all_bytes_write_n_i;
	a_oe_async: assert property (output_enable_n_i |-> !dq_oe_o) else $error("drives with enable off");
	a_parity_dir: assert property (parity_io_oe_o == dq_oe_o) else $error("parity direction split");
	a_sleep_quiet: assert property (sleep_request_i [*6] |-> !dq_oe_o) else $error("drives asleep");
	a_write_tristate: assert property (sel && cs && !ps && !all_bytes_write_n_i |=> !dq_oe_o)
		else $error("drives on write");
	a_read_drive: assert property ((!sleep_request_i) [*6] ##0 sel && ps ##1 rd_ok |-> dq_oe_o)
		else $error("read not driven");
	a_proc_first: assert property ((!sleep_request_i) [*6] ##0 sel && ps && cs && !all_bytes_write_n_i
		##1 rd_ok |-> dq_oe_o) else $error("proc strobe lost");
	a_deselect_c: assert property (chip_select_c_n_i && cs && !ps |=> !dq_oe_o)
		else $error("drives while deselected");
	a_bad_addr: assert property (psel_i && !penable_i && paddr_i != 8'h00 && paddr_i != 8'h04 |=> pslverr_o)
		else $error("unmapped access accepted");
endmodule
bind sbs_sram_ctrl sbs_sram_chk i_sbs_sram_chk (.clk_i, .rst_n_i, .chip_select_a_n_i, .chip_select_b_i,
	.chip_select_c_n_i, .proc_addr_strobe_n_i, .ctrl_addr_strobe_n_i, .all_bytes_write_n_i,
	.output_enable_n_i, .sleep_request_i, .dq_oe_o, .parity_io_oe_o, .psel_i, .penable_i, .paddr_i, .pslverr_o);
`default_nettype wire

// File: test/sbs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side of the shared data and parity lines
module sbs_host_model (
	input wire logic clk_i,
	input wire logic [31:0] dev_dq_i,
	input wire logic [3:0] dev_par_i,
	input wire logic dev_oe_i,
	input wire logic drive_i,
	input wire logic oe_clash_i,
	input wire logic oe_off_i,
	input wire logic [35:0] wdata_i,
	output logic [35:0] line_o,
	output logic oe_n_o
);
	logic [35:0] last = 36'h0;
	// no pull on these lines, so a released line shows the inverse of its last level
	assign line_o = dev_oe_i ? {dev_par_i, dev_dq_i} : drive_i ? wdata_i : ~last;
	always @(posedge clk_i) last <= line_o;
	// enable is kept off while write data are driven, unless a clash is ordered
	assign oe_n_o = drive_i ? !oe_clash_i : oe_off_i;
endmodule
`default_nettype wire

// File: test/test_sbs_sram_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_sbs_sram_ctrl;
	logic clk_i = 0, rst_n_i = 0, pa = 1, pc = 1, st = 1, gw = 1, byte_write_gate_n = 1, drv = 0, clash = 0, oeoff = 0;
	logic sa = 0, sb = 1, sc = 0, slp = 0, mode = 1, psel = 0, pen = 0, pwr = 0, e, dq_oe, par_oe, rdy, err;
	logic [3:0] lsel = 4'hf, par_i, par_o;
	logic [16:0] ad = 17'h0;
	logic [35:0] wd = 36'h0;
	logic [7:0] pad = 8'h0;
	logic [31:0] pwd = 32'h0, r, prd, dq_i, dq_o;
	logic oe_n;
	int bad_count = 0, check_count = 0;
	localparam logic [16:0] base = 17'h15a8c;
	// {mode, start, four expected two-bit low addresses of the burst}
	logic [10:0] rows [8] = '{11'h4e4, 11'h5b1, 11'h64e, 11'h71b, 11'h0e4, 11'h139, 11'h24e, 11'h393};
	sbs_sram_ctrl i_sbs_sram_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(ad), .chip_select_a_n_i(sa),
		.chip_select_b_i(sb), .chip_select_c_n_i(sc), .proc_addr_strobe_n_i(pa), .ctrl_addr_strobe_n_i(pc),
		.burst_step_n_i(st), .all_bytes_write_n_i(gw), .byte_write_gate_n_i(byte_write_gate_n), .lane_write_sel_n_i(lsel),
		.output_enable_n_i(oe_n), .sleep_request_i(slp), .mode_strap_i(mode), .dq_i(dq_i), .dq_o(dq_o),
		.dq_oe_o(dq_oe), .parity_io_i(par_i), .parity_io_o(par_o), .parity_io_oe_o(par_oe), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
		.pslverr_o(err));
	sbs_host_model i_sbs_host_model (.clk_i(clk_i), .dev_dq_i(dq_o), .dev_par_i(par_o), .dev_oe_i(dq_oe),
		.drive_i(drv), .oe_clash_i(clash), .oe_off_i(oeoff), .wdata_i(wd), .line_o({par_i, dq_i}), .oe_n_o(oe_n));
	initial forever #5 clk_i = ~clk_i;
	function automatic [35:0] wv(input int i);
		wv = {4'h9 ^ 4'(i), 32'h3c96_a500 + 32'(i)};
	endfunction
	task cmp(input [36:0] got, input [36:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one memory cycle, k = {proc, ctrl, step, all-bytes write, lane write}
	task op(input [4:0] k, input [16:0] a, input [35:0] d);
		@(posedge clk_i);
		{pa, pc, st, gw, byte_write_gate_n} <= ~k;
		drv <= |k[1:0];
		ad <= a;
		wd <= d;
	endtask
	// outputs are looked at mid-cycle, once the edge's updates have landed
	task rd(input [35:0] x);
		@(negedge clk_i);
		cmp({dq_oe, par_o, dq_o}, {1'b1, x});
	endtask
	task oe(input x);
		@(negedge clk_i);
		cmp(37'({dq_oe, par_oe}), 37'({x, x}));
	endtask
	// idle first, so a write just issued has landed before the read is taken
	task rdat(input [16:0] a, input [35:0] x);
		op(5'h00, 17'h0, 36'h0);
		op(5'h10, a, 36'h0);
		op(5'h00, 17'h0, 36'h0);
		rd(x);
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		int n;
		@(posedge clk_i);
		{psel, pen, pwr, pad, pwd} <= {2'b10, w, a, d};
		@(posedge clk_i);
		pen <= 1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (n == 50) begin
			bad_count++;
			results;
		end
		r = prd;
		e = err;
		{psel, pen} <= 2'b00;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		cmp(37'({dq_oe, err, |prd}), 37'h0);
		rst_n_i <= 1;
		for (int i = 0; i < 4; i++) op(5'h0a, base | 17'(i), wv(i));
		for (int j = 0; j < 8; j++) begin
			@(posedge clk_i) mode <= rows[j][10];
			repeat (6) op(5'h00, 17'h0, 36'h0);
			apb(0, 8'h04, 32'h0);
			cmp(37'(r[1]), 37'(rows[j][10]));
			op(5'h10, base | 17'(rows[j][9:8]), 36'h0);
			for (int k = 0; k < 4; k++) begin
				op(5'h04, 17'h0, 36'h0);
				rd(wv(int'(rows[j][2*k +: 2])));
			end
		end
		// enable off at the start, then on in the next cycle without any clock
		op(5'h10, base, 36'h0);
		oeoff <= 1;
		oe(0);
		op(5'h00, 17'h0, 36'h0);
		oeoff <= 0;
		rd(wv(0));
		clash <= 1;
		op(5'h0a, base, wv(0));
		op(5'h00, 17'h0, 36'h0);
		oe(0);
		op(5'h1a, base | 17'h1, 36'h0);
		op(5'h00, 17'h0, 36'h0);
		clash <= 0;
		rd(wv(1));
		@(posedge clk_i) lsel <= 4'he;
		op(5'h09, base | 17'h2, 36'h0);
		rdat(base | 17'h2, wv(2) & ~36'h1_0000_00ff);
		@(posedge clk_i) lsel <= 4'hf;
		op(5'h0b, base | 17'h2, wv(2));
		rdat(base | 17'h2, wv(2));
		for (int j = 0; j < 2; j++) begin
			op(5'h08, base, 36'h0);
			{sb, sc} <= j[0] ? 2'b00 : 2'b11;
			op(5'h00, 17'h0, 36'h0);
			oe(0);
			op(5'h00, 17'h0, 36'h0);
			{sb, sc} <= 2'b10;
		end
		slp <= 1;
		repeat (6) op(5'h00, 17'h0, 36'h0);
		op(5'h10, base, 36'h0);
		op(5'h00, 17'h0, 36'h0);
		oe(0);
		op(5'h0a, base, 36'h0);
		slp <= 0;
		repeat (6) op(5'h00, 17'h0, 36'h0);
		rdat(base, wv(0));
		apb(1, 8'h00, 32'h1);
		apb(0, 8'h00, 32'h0);
		cmp(37'({e, r}), 37'h1);
		apb(0, 8'h04, 32'h0);
		cmp(37'({e, r[0]}), 37'h1);
		apb(1, 8'h00, 32'h0);
		apb(0, 8'h08, 32'h0);
		cmp(37'({e, r}), 37'h1_0000_0000);
		apb(1, 8'h04, 32'h0);
		cmp(37'(e), 37'h1);
		results;
	end
endmodule
`default_nettype wire
